/* logic/mifd_cfg.svh */
// Field positions, timing figures and reset values for the instruction decoder.
// Included by the phase divider and decoder modules; holds definitions only.
`ifndef MIFD_CFG_SVH
`define MIFD_CFG_SVH

// Instruction word layout
`define MIFD_WORD_W      14
`define MIFD_CLS_MSB     13
`define MIFD_CLS_LSB     12
`define MIFD_CODE_MSB    11
`define MIFD_CODE_LSB    8
`define MIFD_F_MSB       6
`define MIFD_F_LSB       0
`define MIFD_D_BIT       7
`define MIFD_B_MSB       9
`define MIFD_B_LSB       7
`define MIFD_K8_MSB      7
`define MIFD_K11_MSB     10
`define MIFD_K_LSB       0
`define MIFD_GOTO_BIT    11

// Instruction cycle: oscillator periods per cycle and last phase index
`define MIFD_OSC_PER_CYC 4
`define MIFD_PHASE_LAST  2'h3
`define MIFD_PHASE_RST   2'h0

// Default span of I/O port registers read from the pins
`define MIFD_PORT_LO     7'h05
`define MIFD_PORT_HI     7'h09

`endif

/* logic/mifd_pkg.sv */
// Types shared by the instruction decoder modules.
// Assumes nothing beyond the field layout header.
package mifd_pkg;

   // Instruction classes
   typedef enum logic [1:0] {
      CLS_BYTE = 2'h0,
      CLS_BIT  = 2'h1,
      CLS_LIT  = 2'h2
   } mifd_class_t;

   // Decoded operations; OP_BAD marks an unassigned encoding
   typedef enum logic [5:0] {
      OP_NOP    = 6'h00, OP_MOVWF  = 6'h01, OP_CLRW   = 6'h02, OP_CLRF   = 6'h03,
      OP_SUBWF  = 6'h04, OP_DECF   = 6'h05, OP_IORWF  = 6'h06, OP_ANDWF  = 6'h07,
      OP_XORWF  = 6'h08, OP_ADDWF  = 6'h09, OP_MOVF   = 6'h0A, OP_COMF   = 6'h0B,
      OP_INCF   = 6'h0C, OP_DECFSZ = 6'h0D, OP_RRF    = 6'h0E, OP_RLF    = 6'h0F,
      OP_SWAPF  = 6'h10, OP_INCFSZ = 6'h11, OP_BCF    = 6'h12, OP_BSF    = 6'h13,
      OP_BTFSC  = 6'h14, OP_BTFSS  = 6'h15, OP_CALL   = 6'h16, OP_GOTO   = 6'h17,
      OP_MOVLW  = 6'h18, OP_RETLW  = 6'h19, OP_IORLW  = 6'h1A, OP_ANDLW  = 6'h1B,
      OP_XORLW  = 6'h1C, OP_SUBLW  = 6'h1D, OP_ADDLW  = 6'h1E, OP_RETURN = 6'h1F,
      OP_RETFIE = 6'h20, OP_SLEEP  = 6'h21, OP_CLRWDT = 6'h22, OP_BAD    = 6'h3F
   } mifd_op_t;

   // Execution state of the current instruction cycle
   typedef enum logic [0:0] {
      ST_EXEC  = 1'b0,
      ST_FLUSH = 1'b1
   } mifd_state_t;

endpackage

/* logic/mifd_seq_if.sv */
// Carrier between the phase divider and the decoder.
// Both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface mifd_seq_if;
   logic [1:0] phase;
   logic       cycle_last;
   modport src (output phase, output cycle_last);
   modport snk (input phase, input cycle_last);
endinterface
`default_nettype wire

/* logic/mifd_phase.sv */
// Phase divider: four oscillator periods make one instruction cycle.
// Assumes clk_sys is the oscillator clock and srst is synchronous.
`include "mifd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mifd_phase
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic srst,
   // Phase towards the decoder
   mifd_seq_if.src   seq
);

   logic [1:0] phase_reg;
   logic [1:0] phase_next;

   // Wrap after the last phase of the cycle
   always_comb
   begin
      if (phase_reg == `MIFD_PHASE_LAST)
         phase_next = `MIFD_PHASE_RST;
      else
         phase_next = phase_reg + 2'h1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         phase_reg <= `MIFD_PHASE_RST;
      else
         phase_reg <= phase_next;
   end

   assign seq.phase      = phase_reg;
   assign seq.cycle_last = (phase_reg == `MIFD_PHASE_LAST);

   // One cycle end, then exactly three periods without one
   sequence cyc_gap_s;
      !seq.cycle_last [*3] ##1 seq.cycle_last;
   endsequence
   cycle_span_a: assert property (@(posedge clk_sys) disable iff (srst)
      seq.cycle_last |=> cyc_gap_s)
      else $error("instruction cycle not four periods");

endmodule
`default_nettype wire

/* logic/mifd_decoder.sv */
// Instruction field decoder with instruction cycle sequencing.
// Assumes program memory holds the fetched word on instr_word in the last phase
// of each cycle and the datapath drives cond_true during that phase.
`include "mifd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mifd_decoder
#(
   parameter logic [6:0] PORT_LO = `MIFD_PORT_LO,
   parameter logic [6:0] PORT_HI = `MIFD_PORT_HI
)
(
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   // Program memory side
   input  wire logic [13:0]           instr_word,
   output logic                       fetch_strobe_reg,
   // Datapath status
   input  wire logic                  cond_true,
   // Decoded fields
   output mifd_pkg::mifd_op_t         op_reg,
   output mifd_pkg::mifd_class_t      class_reg,
   output logic [6:0]                 file_addr_reg,
   output logic                       dest_file_reg,
   output logic [2:0]                 bit_num_reg,
   output logic [10:0]                literal_reg,
   output logic                       lit_wide_reg,
   output logic                       src_pins_reg,
   // Cycle timing
   output logic                       nop_cycle_reg,
   output logic [1:0]                 phase_reg
);

   mifd_seq_if seq ();

   mifd_phase u_phase
   (
      .clk_sys (clk_sys),
      .srst    (srst),
      .seq     (seq)
   );

   // Class from the two top bits; both literal codes share a class
   function automatic mifd_pkg::mifd_class_t word_class(input logic [13:0] w);
      unique case (w[`MIFD_CLS_MSB:`MIFD_CLS_LSB])
         // Returns, sleep and watchdog clear sit in byte space but are control operations
         2'h0:    word_class = ((w[`MIFD_CODE_MSB:`MIFD_D_BIT] == 5'h00) &&
                                (w[`MIFD_F_MSB:`MIFD_F_LSB] inside {7'h08, 7'h09, 7'h63, 7'h64})) ?
                               mifd_pkg::CLS_LIT : mifd_pkg::CLS_BYTE;
         2'h1:    word_class = mifd_pkg::CLS_BIT;
         default: word_class = mifd_pkg::CLS_LIT;
      endcase
   endfunction

   // Full opcode decode; don't-care bits are left out of every compare
   function automatic mifd_pkg::mifd_op_t word_op(input logic [13:0] w);
      logic [3:0] code;
      code = w[`MIFD_CODE_MSB:`MIFD_CODE_LSB];
      word_op = mifd_pkg::OP_BAD;
      unique case (w[`MIFD_CLS_MSB:`MIFD_CLS_LSB])
         2'h0:
         begin
            unique case (code)
               4'h0:
               begin
                  if (w[`MIFD_D_BIT])
                     word_op = mifd_pkg::OP_MOVWF;
                  else if (w[4:0] == 5'h00)
                     word_op = mifd_pkg::OP_NOP;
                  else if (w[6:0] == 7'h08)
                     word_op = mifd_pkg::OP_RETURN;
                  else if (w[6:0] == 7'h09)
                     word_op = mifd_pkg::OP_RETFIE;
                  else if (w[6:0] == 7'h63)
                     word_op = mifd_pkg::OP_SLEEP;
                  else if (w[6:0] == 7'h64)
                     word_op = mifd_pkg::OP_CLRWDT;
               end
               4'h1:    word_op = w[`MIFD_D_BIT] ? mifd_pkg::OP_CLRF : mifd_pkg::OP_CLRW;
               4'h2:    word_op = mifd_pkg::OP_SUBWF;
               4'h3:    word_op = mifd_pkg::OP_DECF;
               4'h4:    word_op = mifd_pkg::OP_IORWF;
               4'h5:    word_op = mifd_pkg::OP_ANDWF;
               4'h6:    word_op = mifd_pkg::OP_XORWF;
               4'h7:    word_op = mifd_pkg::OP_ADDWF;
               4'h8:    word_op = mifd_pkg::OP_MOVF;
               4'h9:    word_op = mifd_pkg::OP_COMF;
               4'hA:    word_op = mifd_pkg::OP_INCF;
               4'hB:    word_op = mifd_pkg::OP_DECFSZ;
               4'hC:    word_op = mifd_pkg::OP_RRF;
               4'hD:    word_op = mifd_pkg::OP_RLF;
               4'hE:    word_op = mifd_pkg::OP_SWAPF;
               default: word_op = mifd_pkg::OP_INCFSZ;
            endcase
         end
         2'h1:
         begin
            unique case (code[3:2])
               2'h0:    word_op = mifd_pkg::OP_BCF;
               2'h1:    word_op = mifd_pkg::OP_BSF;
               2'h2:    word_op = mifd_pkg::OP_BTFSC;
               default: word_op = mifd_pkg::OP_BTFSS;
            endcase
         end
         2'h2:    word_op = w[`MIFD_GOTO_BIT] ? mifd_pkg::OP_GOTO : mifd_pkg::OP_CALL;
         default:
         begin
            // Low code bits are don't-care for the wide groups
            if (code[3:2] == 2'h0)
               word_op = mifd_pkg::OP_MOVLW;
            else if (code[3:2] == 2'h1)
               word_op = mifd_pkg::OP_RETLW;
            else if (code == 4'h8)
               word_op = mifd_pkg::OP_IORLW;
            else if (code == 4'h9)
               word_op = mifd_pkg::OP_ANDLW;
            else if (code == 4'hA)
               word_op = mifd_pkg::OP_XORLW;
            else if (code[3:1] == 3'h6)
               word_op = mifd_pkg::OP_SUBLW;
            else
               word_op = mifd_pkg::OP_ADDLW;
         end
      endcase
   endfunction

   // Operations that always change the program counter
   function automatic logic changes_pc(input mifd_pkg::mifd_op_t op);
      changes_pc = (op == mifd_pkg::OP_GOTO) || (op == mifd_pkg::OP_CALL) ||
                   (op == mifd_pkg::OP_RETURN) || (op == mifd_pkg::OP_RETLW) ||
                   (op == mifd_pkg::OP_RETFIE);
   endfunction

   // Read-modify-write of the addressed file register
   function automatic logic rmw_op(input mifd_pkg::mifd_op_t op, input logic d);
      rmw_op = ((op == mifd_pkg::OP_BCF) || (op == mifd_pkg::OP_BSF)) ||
               (d && (op != mifd_pkg::OP_MOVWF) && (op != mifd_pkg::OP_CLRF) &&
                (op >= mifd_pkg::OP_SUBWF) && (op <= mifd_pkg::OP_INCFSZ));
   endfunction

   mifd_pkg::mifd_state_t  state_reg,  state_next;
   mifd_pkg::mifd_op_t     op_next,    dec_op;
   mifd_pkg::mifd_class_t  class_next;
   logic [6:0]             file_next;
   logic                   dest_next, wide_next, pins_next, nop_next, fetch_next, take_two;
   logic [2:0]             bit_next;
   logic [10:0]            lit_next;
   logic [1:0]             phase_next;

   // Next decode state; the word is taken at the last phase of each cycle
   always_comb
   begin
      dec_op     = word_op(instr_word);
      take_two   = (state_reg == mifd_pkg::ST_EXEC) && (changes_pc(op_reg) || cond_true);
      state_next = state_reg;
      op_next    = op_reg;
      class_next = class_reg;
      file_next  = file_addr_reg;
      dest_next  = dest_file_reg;
      bit_next   = bit_num_reg;
      lit_next   = literal_reg;
      wide_next  = lit_wide_reg;
      pins_next  = src_pins_reg;
      nop_next   = nop_cycle_reg;
      fetch_next = (seq.phase == `MIFD_PHASE_LAST - 2'h1);
      // Output copy of the divider, one flop so it tracks the internal phase exactly
      phase_next = (seq.phase == `MIFD_PHASE_LAST) ? `MIFD_PHASE_RST : seq.phase + 2'h1;
      if (seq.cycle_last)
      begin
         if (take_two)
         begin
            // Second cycle runs as a no-operation; the prefetched word is dropped
            state_next = mifd_pkg::ST_FLUSH;
            op_next    = mifd_pkg::OP_NOP;
            pins_next  = 1'b0;
            nop_next   = 1'b1;
         end
         else
         begin
            state_next = mifd_pkg::ST_EXEC;
            op_next    = dec_op;
            class_next = word_class(instr_word);
            file_next  = instr_word[`MIFD_F_MSB:`MIFD_F_LSB];
            dest_next  = instr_word[`MIFD_D_BIT];
            bit_next   = instr_word[`MIFD_B_MSB:`MIFD_B_LSB];
            wide_next  = (dec_op == mifd_pkg::OP_GOTO) || (dec_op == mifd_pkg::OP_CALL);
            // Narrow literals read as zero above bit 7
            lit_next   = wide_next ? instr_word[`MIFD_K11_MSB:`MIFD_K_LSB]
                                   : {3'h0, instr_word[`MIFD_K8_MSB:`MIFD_K_LSB]};
            // Read-modify-write port accesses read the pins so input pins are not overwritten by stale latches
            pins_next  = rmw_op(dec_op, instr_word[`MIFD_D_BIT]) &&
                         (instr_word[`MIFD_F_MSB:`MIFD_F_LSB] >= PORT_LO) &&
                         (instr_word[`MIFD_F_MSB:`MIFD_F_LSB] <= PORT_HI);
            nop_next   = 1'b0;
         end
      end
   end

   // Register stage; reset starts in a flush so the first word is taken cleanly
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         state_reg        <= mifd_pkg::ST_FLUSH;
         op_reg           <= mifd_pkg::OP_NOP;
         class_reg        <= mifd_pkg::CLS_BYTE;
         file_addr_reg    <= 7'h00;
         dest_file_reg    <= 1'b0;
         bit_num_reg      <= 3'h0;
         literal_reg      <= 11'h000;
         lit_wide_reg     <= 1'b0;
         src_pins_reg     <= 1'b0;
         nop_cycle_reg    <= 1'b1;
         fetch_strobe_reg <= 1'b0;
         phase_reg        <= `MIFD_PHASE_RST;
      end
      else
      begin
         state_reg        <= state_next;
         op_reg           <= op_next;
         class_reg        <= class_next;
         file_addr_reg    <= file_next;
         dest_file_reg    <= dest_next;
         bit_num_reg      <= bit_next;
         literal_reg      <= lit_next;
         lit_wide_reg     <= wide_next;
         src_pins_reg     <= pins_next;
         nop_cycle_reg    <= nop_next;
         fetch_strobe_reg <= fetch_next;
         phase_reg        <= phase_next;
      end
   end

   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (srst);

   sequence take_s;
      seq.cycle_last && !take_two;
   endsequence
   sequence nop_cycle_s;
      nop_cycle_reg && (op_reg == mifd_pkg::OP_NOP);
   endsequence

   class_pick_a: assert property (take_s |=>
      class_reg == word_class($past(instr_word)))
      else $error("class does not match word");
   dest_field_a: assert property (take_s |=> dest_file_reg == $past(instr_word[7]))
      else $error("destination select wrong");
   file_field_a: assert property (take_s |=> file_addr_reg == $past(instr_word[6:0]))
      else $error("file address wrong");
   bit_field_a: assert property (take_s |=> bit_num_reg == $past(instr_word[9:7]))
      else $error("bit number wrong");
   lit_width_a: assert property (take_s ##1 !lit_wide_reg |-> literal_reg[10:8] == 3'h0)
      else $error("narrow literal has high bits");
   wide_lit_a: assert property (take_s and (instr_word[13:12] == 2'h2) |=>
      lit_wide_reg && (literal_reg == $past(instr_word[10:0])))
      else $error("jump literal not eleven bits");
   dc_movlw_a: assert property (take_s and (instr_word[13:10] == 4'hC) |=> op_reg == mifd_pkg::OP_MOVLW)
      else $error("don't-care bits changed decode");
   two_cycle_a: assert property (seq.cycle_last && take_two |=> nop_cycle_s [*4] ##1 !nop_cycle_reg)
      else $error("second cycle not a four-period no-operation");
   one_cycle_a: assert property (take_s |=> !nop_cycle_reg [*4])
      else $error("single cycle instruction stretched");
   pins_src_a: assert property (src_pins_reg |->
      (file_addr_reg >= PORT_LO) && (file_addr_reg <= PORT_HI) && !nop_cycle_reg)
      else $error("pin source outside port range");

endmodule
`default_nettype wire

/* bench/mifd_prog_mem.sv */
// Program memory model: shows the word the bench chose while the decoder fetches.
// Assumes fetch_strobe is high for exactly the fetch phase of each instruction cycle.
`timescale 1ns/1ps
`default_nettype none
module mifd_prog_mem
(
   // Fetch control from the decoder
   input  wire logic        fetch_strobe,
   // Bench controls
   input  wire logic        slow,
   input  wire logic [13:0] word_next,
   // Word towards the decoder
   output logic      [13:0] instr_word
);
   logic [13:0] shown = 14'h3FFF;

   // Outside the fetch phase the bus shows the inverse, so a stray sample is caught
   always @(fetch_strobe)
   begin
      if (fetch_strobe === 1'b1)
      begin
         shown = ~word_next;
         #(slow ? 3.0 : 0.5);  // Slow part settles late in the phase
         shown = word_next;
      end
      else
      begin
         shown = ~word_next;
      end
   end

   assign instr_word = shown;
endmodule
`default_nettype wire

/* bench/mcu_instruction_field_decoder_bench.sv */
// Self-checking bench for the instruction field decoder.
// Assumes the program memory model mifd_prog_mem and a 250 MHz clk_sys.
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_field_decoder_bench;
   localparam logic [6:0] PLO   = 7'h05;
   localparam logic [6:0] PHI   = 7'h09;
   localparam int         LIMIT = 3000;  // Full run needs about 430 cycles

   // Stimulus and bookkeeping
   logic                  clk_sys   = 1'b0;
   logic                  srst      = 1'b1;
   logic                  cond_true = 1'b0;
   logic                  slow      = 1'b0;
   logic [13:0]           word_q    = 14'h0000;
   logic                  pend      = 1'b0;  // Branch executing, next word must drop
   logic                  in_flush  = 1'b1;
   mifd_pkg::mifd_class_t last_cls  = mifd_pkg::CLS_BYTE;
   int                    fails     = 0;
   int                    compares  = 0;
   int                    cycles    = 0;
   // Observed outputs
   wire logic [13:0]      instr_word;
   logic                  fetch_strobe;
   mifd_pkg::mifd_op_t    op;
   mifd_pkg::mifd_class_t cls;
   logic [6:0]            file_addr;
   logic                  dest_file;
   logic [2:0]            bit_num;
   logic [10:0]           literal;
   logic                  lit_wide;
   logic                  src_pins;
   logic                  nop_cycle;
   logic [1:0]            phase;

   mifd_decoder #(.PORT_LO(PLO), .PORT_HI(PHI)) u_dut (.clk_sys(clk_sys), .srst(srst), .instr_word(instr_word),
      .fetch_strobe_reg(fetch_strobe), .cond_true(cond_true), .op_reg(op), .class_reg(cls),
      .file_addr_reg(file_addr), .dest_file_reg(dest_file), .bit_num_reg(bit_num), .literal_reg(literal),
      .lit_wide_reg(lit_wide), .src_pins_reg(src_pins), .nop_cycle_reg(nop_cycle), .phase_reg(phase));

   mifd_prog_mem u_mem (.fetch_strobe(fetch_strobe), .slow(slow), .word_next(word_q), .instr_word(instr_word));

   // 4 ns clock
   initial
   begin
      forever #2 clk_sys = ~clk_sys;
   end

   // Hang guard
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         fails++;
         give_verdict();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      if (fails == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // One fetch: word shown in phase 3, outcome judged after the edge that ends it
   task automatic issue(input logic [13:0] w, input logic c, input mifd_pkg::mifd_op_t eop,
                        input mifd_pkg::mifd_class_t ecls);
      logic nop_exp;
      logic src_exp;
      logic wide;
      int   n;
      nop_exp = pend || (c && !in_flush);
      wide = (eop == mifd_pkg::OP_CALL) || (eop == mifd_pkg::OP_GOTO);
      src_exp = (w[6:0] >= PLO) && (w[6:0] <= PHI) && ((ecls == mifd_pkg::CLS_BYTE && w[7]
                && eop != mifd_pkg::OP_MOVWF && eop != mifd_pkg::OP_CLRF)
                || eop == mifd_pkg::OP_BCF || eop == mifd_pkg::OP_BSF);
      n = 0;
      // Phase is read settled, never in the time step of the edge that moves it
      @(posedge clk_sys);
      #1;
      while (phase !== 2'h2 && n < 8)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n == 8)
         fails++;
      @(posedge clk_sys);
      word_q <= w;
      cond_true <= c;
      #1;
      check(fetch_strobe, 1'b1);
      check(phase, 2'h3);
      @(posedge clk_sys);
      cond_true <= 1'b0;
      #1;
      check(fetch_strobe, 1'b0);
      check(nop_cycle, nop_exp);
      if (nop_exp)
      begin
         check(op, mifd_pkg::OP_NOP);
         check(cls, last_cls);
      end
      else
      begin
         check(op, eop);
         if (eop != mifd_pkg::OP_BAD)
            check(cls, ecls);
         check(file_addr, w[6:0]);
         check(dest_file, w[7]);
         check(bit_num, w[9:7]);
         check(lit_wide, wide);
         check(literal, wide ? w[10:0] : {3'h0, w[7:0]});
         last_cls = ecls;
      end
      check(src_pins, src_exp && !nop_exp);
      pend = !nop_exp && (eop inside {mifd_pkg::OP_CALL, mifd_pkg::OP_GOTO, mifd_pkg::OP_RETURN,
                                      mifd_pkg::OP_RETLW, mifd_pkg::OP_RETFIE});
      in_flush = nop_exp;
   endtask

   // Word plus the discarded follow-up that a branch forces
   task automatic run(input logic [13:0] w, input mifd_pkg::mifd_op_t eop, input mifd_pkg::mifd_class_t ecls);
      issue(w, 1'b0, eop, ecls);
      if (pend)
         issue(14'h2FFF, 1'b1, mifd_pkg::OP_GOTO, mifd_pkg::CLS_LIT);
   endtask

   task automatic t_reset();
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (20) @(posedge clk_sys);
      #1;
      check(phase, 2'h0);
      check(fetch_strobe, 1'b0);
      check(op, mifd_pkg::OP_NOP);
      check(nop_cycle, 1'b1);
      check(literal, 11'h000);
      @(posedge clk_sys);
      srst <= 1'b0;
      pend = 1'b0;
      in_flush = 1'b1;
   endtask

   task automatic t_byte();
      mifd_pkg::mifd_op_t ops [16];
      logic [3:0]         c;
      ops = '{mifd_pkg::OP_NOP, mifd_pkg::OP_CLRW, mifd_pkg::OP_SUBWF, mifd_pkg::OP_DECF,
              mifd_pkg::OP_IORWF, mifd_pkg::OP_ANDWF, mifd_pkg::OP_XORWF, mifd_pkg::OP_ADDWF,
              mifd_pkg::OP_MOVF, mifd_pkg::OP_COMF, mifd_pkg::OP_INCF, mifd_pkg::OP_DECFSZ,
              mifd_pkg::OP_RRF, mifd_pkg::OP_RLF, mifd_pkg::OP_SWAPF, mifd_pkg::OP_INCFSZ};
      for (int i = 2; i < 16; i++)
      begin
         c = 4'(i);
         run({2'b00, c, c[1], c[0] ? 7'h7F : 7'h05}, ops[i], mifd_pkg::CLS_BYTE);
      end
      run(14'h0085, mifd_pkg::OP_MOVWF, mifd_pkg::CLS_BYTE);
      run(14'h0185, mifd_pkg::OP_CLRF, mifd_pkg::CLS_BYTE);
      run(14'h0100, mifd_pkg::OP_CLRW, mifd_pkg::CLS_BYTE);
      run(14'h017F, mifd_pkg::OP_CLRW, mifd_pkg::CLS_BYTE);
      run(14'h0000, mifd_pkg::OP_NOP, mifd_pkg::CLS_BYTE);
      run(14'h0060, mifd_pkg::OP_NOP, mifd_pkg::CLS_BYTE);
   endtask

   task automatic t_bit();
      mifd_pkg::mifd_op_t ops [4];
      logic [4:0]         v;
      ops = '{mifd_pkg::OP_BCF, mifd_pkg::OP_BSF, mifd_pkg::OP_BTFSC, mifd_pkg::OP_BTFSS};
      for (int i = 0; i < 32; i++)
      begin
         v = 5'(i);
         run({2'b01, v, 7'(i * 3)}, ops[v[4:3]], mifd_pkg::CLS_BIT);
      end
   endtask

   task automatic t_lit();
      logic [13:0]        ws [14];
      mifd_pkg::mifd_op_t ops [14];
      ws = '{14'h30A5, 14'h33FF, 14'h3500, 14'h3800, 14'h397F, 14'h3AFF, 14'h3C01,
             14'h3D80, 14'h3E55, 14'h3FAA, 14'h2555, 14'h2AAA, 14'h27FF, 14'h2800};
      ops = '{mifd_pkg::OP_MOVLW, mifd_pkg::OP_MOVLW, mifd_pkg::OP_RETLW, mifd_pkg::OP_IORLW,
              mifd_pkg::OP_ANDLW, mifd_pkg::OP_XORLW, mifd_pkg::OP_SUBLW, mifd_pkg::OP_SUBLW,
              mifd_pkg::OP_ADDLW, mifd_pkg::OP_ADDLW, mifd_pkg::OP_CALL, mifd_pkg::OP_GOTO,
              mifd_pkg::OP_CALL, mifd_pkg::OP_GOTO};
      for (int i = 0; i < 14; i++)
         run(ws[i], ops[i], mifd_pkg::CLS_LIT);
   endtask

   task automatic t_ctrl();
      run(14'h0008, mifd_pkg::OP_RETURN, mifd_pkg::CLS_LIT);
      run(14'h0009, mifd_pkg::OP_RETFIE, mifd_pkg::CLS_LIT);
      run(14'h0063, mifd_pkg::OP_SLEEP, mifd_pkg::CLS_LIT);
      run(14'h0064, mifd_pkg::OP_CLRWDT, mifd_pkg::CLS_LIT);
      run(14'h0001, mifd_pkg::OP_BAD, mifd_pkg::CLS_BYTE);
      // Reset lands while a jump is pending
      issue(14'h2800, 1'b0, mifd_pkg::OP_GOTO, mifd_pkg::CLS_LIT);
      t_reset();
      run(14'h30A5, mifd_pkg::OP_MOVLW, mifd_pkg::CLS_LIT);
   endtask

   // Skip tests, back to back, with late memory data
   task automatic t_skip();
      @(posedge clk_sys);
      slow <= 1'b1;
      run(14'h0B85, mifd_pkg::OP_DECFSZ, mifd_pkg::CLS_BYTE);
      issue(14'h0A00, 1'b1, mifd_pkg::OP_INCF, mifd_pkg::CLS_BYTE);
      issue(14'h0F7F, 1'b1, mifd_pkg::OP_INCFSZ, mifd_pkg::CLS_BYTE);
      issue(14'h1C00, 1'b0, mifd_pkg::OP_BTFSS, mifd_pkg::CLS_BIT);
      issue(14'h1800, 1'b1, mifd_pkg::OP_BTFSC, mifd_pkg::CLS_BIT);
      issue(14'h3000, 1'b0, mifd_pkg::OP_MOVLW, mifd_pkg::CLS_LIT);
      slow <= 1'b0;
   endtask

   task automatic t_pins();
      run(14'h0885, mifd_pkg::OP_MOVF, mifd_pkg::CLS_BYTE);
      run(14'h0889, mifd_pkg::OP_MOVF, mifd_pkg::CLS_BYTE);
      run(14'h088A, mifd_pkg::OP_MOVF, mifd_pkg::CLS_BYTE);
      run(14'h0805, mifd_pkg::OP_MOVF, mifd_pkg::CLS_BYTE);
      run(14'h1404, mifd_pkg::OP_BSF, mifd_pkg::CLS_BIT);
      run(14'h1385, mifd_pkg::OP_BCF, mifd_pkg::CLS_BIT);
      run(14'h1D85, mifd_pkg::OP_BTFSS, mifd_pkg::CLS_BIT);
      run(14'h1789, mifd_pkg::OP_BSF, mifd_pkg::CLS_BIT);
   endtask

   // Phase steps once per clock, strobe only in phase 3
   task automatic t_cadence();
      logic [1:0] p;
      p = phase;
      for (int i = 0; i < 12; i++)
      begin
         @(posedge clk_sys);
         #1;
         p = p + 2'h1;
         check(phase, p);
         check(fetch_strobe, p == 2'h3);
      end
   endtask

   initial
   begin
      t_reset();
      t_byte();
      t_bit();
      t_lit();
      t_ctrl();
      t_skip();
      t_pins();
      t_cadence();
      give_verdict();
   end
endmodule
`default_nettype wire
